// ==== pvce_pkg.sv ====
// constants and types of the vector control engine
package pvce_pkg;

    // clock and pwm timing
    localparam int CLK_HZ = 20_000_000;
    localparam int CLK_MHZ = CLK_HZ / 1_000_000;
    localparam int PWM_HZ = 20_000;
    localparam logic [9:0] PWM_HALF = 10'(CLK_HZ / PWM_HZ / 2);
    localparam int DEAD_NS = 1000;
    localparam logic [4:0] DEAD_CYC = 5'((DEAD_NS * CLK_MHZ + 999) / 1000);

    // start-up alignment, long count kept as top parameter default
    localparam int ALIGN_MS = 500;
    localparam int ALIGN_CYC = ALIGN_MS * (CLK_HZ / 1000);
    localparam logic signed [15:0] ALIGN_V = 16'sh1000;

    // encoder and speed measurement
    localparam int ENC_LINES = 500;
    localparam logic [10:0] ENC_CPR = 11'(ENC_LINES * 4);
    localparam int POLE_PAIRS = 2;
    localparam logic [16:0] ANG_SCALE = 17'((65536 * 1024 * POLE_PAIRS + 1000) / 2000);
    localparam int SPEED_WIN_US = 3000;
    localparam int SPEED_WIN_CYC = SPEED_WIN_US * CLK_MHZ;
    localparam logic [7:0] RPM_PER_COUNT = 8'(60_000_000 / (ENC_LINES * 4 * SPEED_WIN_US));
    localparam logic signed [15:0] SPD_MIN_RPM = 16'sd10;
    localparam logic signed [15:0] SPD_MAX_RPM = 16'sd1000;
    localparam logic signed [15:0] RAMP_STEP = 16'sd20;

    // controller gains, kp in q8 and ki in q10
    localparam logic [15:0] KP_SPD = 16'h0200;
    localparam logic [15:0] KI_SPD = 16'h0040;
    localparam logic [15:0] KP_CUR = 16'h0180;
    localparam logic [15:0] KI_CUR = 16'h0060;

    // current samples, transform scaling
    localparam logic [11:0] ADC_MID = 12'h800;
    localparam logic [9:0] INV_SQRT3_Q10 = 10'h24f;
    localparam logic [9:0] SQRT3_2_Q10 = 10'h377;
    localparam logic [16:0] CORDIC_GAIN_Q16 = 17'h09b75;
    localparam logic [15:0] CORDIC_ATAN [14] = '{16'h2000, 16'h12e4, 16'h09fb, 16'h0511,
        16'h028b, 16'h0146, 16'h00a3, 16'h0051, 16'h0029, 16'h0014, 16'h000a,
        16'h0005, 16'h0003, 16'h0001};

    // brake chopper hysteresis on the dc-bus sample
    localparam logic [11:0] BRAKE_ON = 12'hc00;
    localparam logic [11:0] BRAKE_OFF = 12'hb00;

    // drive states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ALIGN = 3'b010,
        ST_RUN = 3'b100
    } pvce_state_t;

endpackage : pvce_pkg

// ==== pvce_engine.sv ====
// field-oriented pmsm control engine: encoder, loops, svm and pwm
`timescale 1ns/1ns
module pvce_engine #(
    parameter int unsigned P_ALIGN_CYCLES = pvce_pkg::ALIGN_CYC,
    parameter int unsigned P_SPEED_WIN = pvce_pkg::SPEED_WIN_CYC
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // encoder pins
    input wire logic i_enc_a,
    input wire logic i_enc_b,
    input wire logic i_enc_index,
    // fault pin
    input wire logic i_overcurrent,
    // host demands
    input wire logic i_run,
    input wire logic i_speed_mode,
    input wire logic signed [15:0] i_speed_req_rpm,
    input wire logic signed [15:0] i_torque_req,
    input wire logic [14:0] i_iq_limit,
    input wire logic [14:0] i_vdq_limit,
    input wire logic i_pwm_kill,
    input wire logic i_fault_ack,
    // samples copied in by the host
    input wire logic i_cur_valid,
    input wire logic [11:0] i_cur_a_raw,
    input wire logic [11:0] i_cur_b_raw,
    input wire logic [11:0] i_dcbus_raw,
    // power stage
    output logic [2:0] o_pwm_hi,
    output logic [2:0] o_pwm_lo,
    output logic o_brake,
    // adc and host status
    output logic o_adc_trigger,
    output logic o_fault_irq,
    output logic [10:0] o_position,
    output logic [19:0] o_last_edge_time,
    output logic signed [15:0] o_speed_rpm,
    output logic signed [15:0] o_iq,
    output pvce_pkg::pvce_state_t o_state
);
    import pvce_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // symmetric clamp to +-lim
    function automatic logic signed [15:0] sat(input logic signed [35:0] x,
                                               input logic [14:0] lim);
        logic signed [35:0] l;
        begin
            l = 36'({1'b0, lim});
            if (x > l) return 16'(l);
            if (x < -l) return 16'(-l);
            return 16'(x);
        end
    endfunction : sat

    // pi proportional plus integral, clamped
    function automatic logic signed [15:0] pi_out(input logic signed [16:0] err,
        input logic signed [15:0] integ, input logic [15:0] kp, input logic [14:0] lim);
        return sat(((36'(err) * $signed({1'b0, kp})) >>> 8) + 36'(integ), lim);
    endfunction : pi_out

    // integrator holds while the output sits at a limit
    function automatic logic signed [15:0] pi_int(input logic signed [16:0] err,
        input logic signed [15:0] integ, input logic [15:0] ki,
        input logic signed [15:0] out, input logic [14:0] lim);
        if (out == $signed({1'b0, lim}) || out == -$signed({1'b0, lim})) return integ;
        return sat(36'(integ) + ((36'(err) * $signed({1'b0, ki})) >>> 10), lim);
    endfunction : pi_int

    // cordic vector rotation by ang (65536 = one turn), returns {y, x}
    function automatic logic [31:0] rotate(input logic signed [15:0] xi,
        input logic signed [15:0] yi, input logic [15:0] ang);
        logic signed [17:0] x;
        logic signed [17:0] y;
        logic signed [17:0] t;
        logic signed [15:0] z;
        logic signed [35:0] px;
        logic signed [35:0] py;
        begin
            x = 18'(xi);
            y = 18'(yi);
            z = $signed(ang);
            // pre-rotate by a quarter turn so the iteration converges
            if (z > 16'sd16384) begin
                t = x;
                x = -y;
                y = t;
                z = z - 16'sd16384;
            end else if (z < -16'sd16384) begin
                t = x;
                x = y;
                y = -t;
                z = z + 16'sd16384;
            end
            for (int k = 0; k < 14; k++) begin
                t = x;
                if (z >= 16'sd0) begin
                    x = x - (y >>> k);
                    y = y + (t >>> k);
                    z = z - $signed(CORDIC_ATAN[k]);
                end else begin
                    x = x + (y >>> k);
                    y = y - (t >>> k);
                    z = z + $signed(CORDIC_ATAN[k]);
                end
            end
            px = 36'(x) * 36'($signed({1'b0, CORDIC_GAIN_Q16}));
            py = 36'(y) * 36'($signed({1'b0, CORDIC_GAIN_Q16}));
            return {sat(py >>> 16, 15'h7fff), sat(px >>> 16, 15'h7fff)};
        end
    endfunction : rotate

    // phase voltage (q15 of half bus) to compare value around mid-period
    function automatic logic [9:0] to_duty(input logic signed [17:0] v);
        logic signed [35:0] d;
        begin
            // signed scale keeps the shift arithmetic for negative phases
            d = $signed(36'(PWM_HALF / 2))
                + ((36'(v) * $signed(36'(PWM_HALF / 2))) >>> 15);
            if (d < 36'sd0) return 10'h000;
            if (d > 36'(PWM_HALF)) return PWM_HALF;
            return 10'(d);
        end
    endfunction : to_duty

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers, stage 0 is read only by stage 1

    logic [1:0] a_sync; // encoder phase a
    logic [1:0] b_sync; // encoder phase b
    logic [1:0] x_sync; // encoder index
    logic [1:0] oc_sync; // over-current
    logic a_q; // previous settled levels
    logic b_q;
    logic x_q;
    logic oc_q;

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            a_sync <= 2'h0;
            b_sync <= 2'h0;
            x_sync <= 2'h0;
            oc_sync <= 2'h0;
        end else begin
            a_sync <= {a_sync[0], i_enc_a};
            b_sync <= {b_sync[0], i_enc_b};
            x_sync <= {x_sync[0], i_enc_index};
            oc_sync <= {oc_sync[0], i_overcurrent};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // drive state: idle, alignment, run

    pvce_state_t state;
    logic [23:0] align_cnt; // alignment dwell
    logic align_done;
    assign align_done = (align_cnt == 24'(P_ALIGN_CYCLES - 1));

    // run off always returns to idle; faults are left to the host
    always_ff @(posedge i_clock) begin
        if (i_rst || !i_run) begin
            state <= ST_IDLE;
            align_cnt <= 24'h000000;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    state <= ST_ALIGN;
                    align_cnt <= 24'h000000;
                end
                ST_ALIGN: begin
                    align_cnt <= align_cnt + 24'h000001;
                    if (align_done) state <= ST_RUN;
                end
                ST_RUN: state <= ST_RUN;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // quadrature decoder

    logic [10:0] pos; // index-referenced position
    logic [10:0] pos_off; // position captured at end of alignment
    logic signed [15:0] edge_acc; // unwrapped edge count for speed
    logic [19:0] tstamp; // free-running timebase
    logic enc_edge;
    logic enc_up;
    assign enc_edge = (a_sync[1] != a_q) || (b_sync[1] != b_q);
    assign enc_up = a_sync[1] ^ b_q; // phase order gives direction

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            a_q <= 1'b0;
            b_q <= 1'b0;
            x_q <= 1'b0;
            pos <= 11'h000;
            edge_acc <= 16'sh0000;
            tstamp <= 20'h00000;
            o_last_edge_time <= 20'h00000;
        end else begin
            a_q <= a_sync[1];
            b_q <= b_sync[1];
            x_q <= x_sync[1];
            tstamp <= tstamp + 20'h00001;
            if (x_sync[1] && !x_q) begin
                pos <= 11'h000;
            end else if (enc_edge && enc_up) begin
                pos <= (pos == ENC_CPR - 11'h001) ? 11'h000 : pos + 11'h001;
            end else if (enc_edge) begin
                pos <= (pos == 11'h000) ? ENC_CPR - 11'h001 : pos - 11'h001;
            end
            if (enc_edge) begin
                edge_acc <= enc_up ? edge_acc + 16'sh0001 : edge_acc - 16'sh0001;
                o_last_edge_time <= tstamp;
            end
        end
    end

    // the aligned rotor defines electrical zero
    always_ff @(posedge i_clock) begin
        if (i_rst) pos_off <= 11'h000;
        else if (state == ST_ALIGN && align_done) pos_off <= pos;
    end

    assign o_position = pos;

    // electrical angle of the rotor
    logic [10:0] pos_rel;
    logic [27:0] ang_prod;
    logic [15:0] theta;
    assign pos_rel = (pos >= pos_off) ? pos - pos_off : pos + ENC_CPR - pos_off;
    assign ang_prod = 28'(pos_rel) * 28'(ANG_SCALE);
    assign theta = ang_prod[25:10]; // wraps once per pole pair

    ////////////////////////////////////////////////////////////////////////////
    // speed loop: measurement, ramp and pi, once per window

    logic [15:0] win_cnt;
    logic [19:0] win_cnt_hi;
    logic win_tick;
    logic signed [15:0] win_ref; // edge count at last window
    logic signed [15:0] ramp; // ramped demand
    logic signed [15:0] target; // clamped demand
    logic signed [15:0] spd_int; // speed integrator
    logic signed [15:0] iq_spd; // speed pi output
    logic signed [16:0] spd_err;
    logic signed [15:0] iq_spd_next;
    assign win_tick = ({win_cnt_hi[3:0], win_cnt} == 20'(P_SPEED_WIN - 1));
    assign spd_err = 17'(ramp) - 17'(o_speed_rpm);
    assign iq_spd_next = pi_out(spd_err, spd_int, KP_SPD, i_iq_limit);

    // signed demand, so both directions and braking use the same path
    always_comb begin
        if (i_speed_req_rpm > SPD_MAX_RPM) target = SPD_MAX_RPM;
        else if (i_speed_req_rpm < -SPD_MAX_RPM) target = -SPD_MAX_RPM;
        else if (i_speed_req_rpm < SPD_MIN_RPM && i_speed_req_rpm > -SPD_MIN_RPM) target = 16'sh0;
        else target = i_speed_req_rpm;
    end

    // window timer and speed measurement
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            win_cnt <= 16'h0000;
            win_cnt_hi <= 20'h00000;
            win_ref <= 16'sh0000;
            o_speed_rpm <= 16'sh0000;
        end else if (win_tick) begin
            win_cnt <= 16'h0000;
            win_cnt_hi <= 20'h00000;
            win_ref <= edge_acc;
            o_speed_rpm <= 16'((edge_acc - win_ref) * $signed({1'b0, RPM_PER_COUNT}));
        end else begin
            {win_cnt_hi[3:0], win_cnt} <= {win_cnt_hi[3:0], win_cnt} + 20'h00001;
        end
    end

    // ramp limiter and speed pi; cleared outside run
    always_ff @(posedge i_clock) begin
        if (i_rst || state != ST_RUN) begin
            ramp <= 16'sh0000;
            spd_int <= 16'sh0000;
            iq_spd <= 16'sh0000;
        end else if (win_tick) begin
            if (target > ramp + RAMP_STEP) ramp <= ramp + RAMP_STEP;
            else if (target < ramp - RAMP_STEP) ramp <= ramp - RAMP_STEP;
            else ramp <= target;
            iq_spd <= iq_spd_next;
            spd_int <= pi_int(spd_err, spd_int, KI_SPD, iq_spd_next, i_iq_limit);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // current loop pipeline, one stage per cycle after a sample arrives

    logic [3:0] stage; // valid flags of the pipeline
    logic signed [15:0] ia; // preprocessed samples, q15
    logic signed [15:0] ib;
    logic signed [15:0] id_meas;
    logic signed [15:0] vd;
    logic signed [15:0] vq;
    logic signed [15:0] d_int;
    logic signed [15:0] q_int;
    logic signed [15:0] v_alpha;
    logic signed [15:0] v_beta;
    logic signed [15:0] i_beta;
    logic signed [15:0] iq_ref;
    logic signed [16:0] d_err;
    logic signed [16:0] q_err;
    logic signed [15:0] vd_next;
    logic signed [15:0] vq_next;
    logic [31:0] park;
    logic [31:0] ipark;
    assign i_beta = sat((36'(ia) + 36'(ib) * 36'sd2) * $signed(36'(INV_SQRT3_Q10)) >>> 10,
                        15'h7fff);
    assign park = rotate(ia, i_beta, 16'(16'h0000 - theta));
    assign iq_ref = i_speed_mode ? iq_spd : sat(36'(i_torque_req), i_iq_limit);
    assign d_err = 17'sh0 - 17'(id_meas);
    assign q_err = 17'(iq_ref) - 17'(o_iq);
    assign vd_next = pi_out(d_err, d_int, KP_CUR, i_vdq_limit);
    assign vq_next = pi_out(q_err, q_int, KP_CUR, i_vdq_limit);
    assign ipark = rotate(vd, vq, theta);

    // samples, transforms and pi; alignment overrides the voltage
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            stage <= 4'h0;
            ia <= 16'sh0000;
            ib <= 16'sh0000;
            id_meas <= 16'sh0000;
            o_iq <= 16'sh0000;
            vd <= 16'sh0000;
            vq <= 16'sh0000;
            d_int <= 16'sh0000;
            q_int <= 16'sh0000;
            v_alpha <= 16'sh0000;
            v_beta <= 16'sh0000;
        end else begin
            stage <= {stage[2:0], i_cur_valid};
            if (i_cur_valid) begin
                ia <= 16'({i_cur_a_raw - ADC_MID, 4'h0});
                ib <= 16'({i_cur_b_raw - ADC_MID, 4'h0});
            end
            if (stage[0]) begin
                id_meas <= park[15:0];
                o_iq <= park[31:16];
            end
            if (state != ST_RUN) begin
                d_int <= 16'sh0000;
                q_int <= 16'sh0000;
                vd <= 16'sh0000;
                vq <= 16'sh0000;
            end else if (stage[1]) begin
                vd <= vd_next;
                vq <= vq_next;
                d_int <= pi_int(d_err, d_int, KI_CUR, vd_next, i_vdq_limit);
                q_int <= pi_int(q_err, q_int, KI_CUR, vq_next, i_vdq_limit);
            end
            if (state == ST_ALIGN) begin
                v_alpha <= ALIGN_V;
                v_beta <= 16'sh0000;
            end else if (stage[2]) begin
                v_alpha <= ipark[15:0];
                v_beta <= ipark[31:16];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // space vector modulation with min-max offset injection

    logic signed [17:0] v_ph [3];
    logic signed [17:0] v_max;
    logic signed [17:0] v_min;
    logic signed [17:0] v_off;
    logic signed [35:0] vb_part;

    always_comb begin
        vb_part = (36'(v_beta) * $signed(36'(SQRT3_2_Q10))) >>> 10;
        v_ph[0] = 18'(v_alpha);
        v_ph[1] = 18'(-(v_alpha >>> 1)) + 18'(vb_part);
        v_ph[2] = 18'(-(v_alpha >>> 1)) - 18'(vb_part);
        v_max = v_ph[0];
        v_min = v_ph[0];
        for (int k = 1; k < 3; k++) begin
            if (v_ph[k] > v_max) v_max = v_ph[k];
            if (v_ph[k] < v_min) v_min = v_ph[k];
        end
        v_off = (v_max + v_min) >>> 1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // centre-aligned pwm with dead time

    logic [9:0] carrier;
    logic up;
    logic period_start;
    logic [9:0] duty_new [3]; // computed, not yet applied
    logic [9:0] duty_act [3]; // applied from period start
    logic [4:0] dt_cnt [3];
    logic [2:0] raw_prev;
    logic [2:0] raw;
    logic pwm_en;
    assign period_start = (carrier == 10'h000);
    assign pwm_en = (state != ST_IDLE) && !oc_sync[1] && !i_pwm_kill;
    always_comb begin
        for (int k = 0; k < 3; k++) raw[k] = carrier < duty_act[k];
    end

    // triangle carrier, one period of 2 * PWM_HALF cycles
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            carrier <= 10'h000;
            up <= 1'b1;
            o_adc_trigger <= 1'b0;
        end else begin
            o_adc_trigger <= period_start;
            if (up) begin
                carrier <= carrier + 10'h001;
                if (carrier == PWM_HALF - 10'h001) up <= 1'b0;
            end else begin
                carrier <= carrier - 10'h001;
                if (carrier == 10'h001) up <= 1'b1;
            end
        end
    end

    // new duties taken only at period start, all phases together
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            for (int k = 0; k < 3; k++) begin
                duty_new[k] <= PWM_HALF >> 1;
                duty_act[k] <= PWM_HALF >> 1;
            end
        end else begin
            if (stage[3] || state == ST_ALIGN) begin
                for (int k = 0; k < 3; k++) duty_new[k] <= to_duty(v_ph[k] - v_off);
            end
            if (period_start) begin
                for (int k = 0; k < 3; k++) duty_act[k] <= duty_new[k];
            end
        end
    end

    // both switches off for DEAD_CYC + 1 cycles after any change of a leg
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            raw_prev <= 3'h0;
            o_pwm_hi <= 3'h0;
            o_pwm_lo <= 3'h0;
            for (int k = 0; k < 3; k++) dt_cnt[k] <= 5'h00;
        end else begin
            raw_prev <= raw;
            for (int k = 0; k < 3; k++) begin
                if (raw[k] != raw_prev[k]) dt_cnt[k] <= DEAD_CYC;
                else if (dt_cnt[k] != 5'h00) dt_cnt[k] <= dt_cnt[k] - 5'h01;
                o_pwm_hi[k] <= pwm_en && raw[k] && raw[k] == raw_prev[k]
                               && dt_cnt[k] == 5'h00;
                o_pwm_lo[k] <= pwm_en && !raw[k] && raw[k] == raw_prev[k]
                               && dt_cnt[k] == 5'h00;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // fault request and brake chopper

    // sticky request; a new fault edge beats the host acknowledge
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            oc_q <= 1'b0;
            o_fault_irq <= 1'b0;
        end else begin
            oc_q <= oc_sync[1];
            if (oc_sync[1] && !oc_q) o_fault_irq <= 1'b1;
            else if (i_fault_ack) o_fault_irq <= 1'b0;
        end
    end

    // hysteresis avoids chattering around one threshold
    always_ff @(posedge i_clock) begin
        if (i_rst) o_brake <= 1'b0;
        else if (i_dcbus_raw >= BRAKE_ON) o_brake <= 1'b1;
        else if (i_dcbus_raw <= BRAKE_OFF) o_brake <= 1'b0;
    end

    assign o_state = state;

endmodule : pvce_engine

// ==== pvce_monitor.sv ====
// assertion checker of the engine ports
`timescale 1ns/1ns
module pvce_monitor import pvce_pkg::*; (
    // clock, reset and inputs
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_run,
    input wire logic i_overcurrent,
    input wire logic i_pwm_kill,
    input wire logic i_enc_index,
    // watched outputs
    input wire logic [2:0] o_pwm_hi,
    input wire logic [2:0] o_pwm_lo,
    input wire logic o_adc_trigger,
    input wire logic o_fault_irq,
    input wire logic [10:0] o_position,
    input wire pvce_pkg::pvce_state_t o_state
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);
    wire logic [2:0] gate_any = o_pwm_hi | o_pwm_lo; // any switch on
    // pin held past sync and register latency
    sequence s_oc_held; i_overcurrent[*5]; endsequence
    property p_no_shoot; (o_pwm_hi & o_pwm_lo) == 3'h0; endproperty
    a_no_shoot: assert property (p_no_shoot) else $error("both switches on");
    property p_dead; $fell(o_pwm_lo[0]) |-> !o_pwm_hi[0] [*8]; endproperty
    a_dead: assert property (p_dead) else $error("dead time short");
    property p_oc_off; s_oc_held |-> gate_any == 3'h0; endproperty
    a_oc_off: assert property (p_oc_off) else $error("pwm on in fault");
    property p_kill; i_pwm_kill [*2] |-> gate_any == 3'h0; endproperty
    a_kill: assert property (p_kill) else $error("pwm on when killed");
    property p_irq; $rose(i_overcurrent) |-> ##[1:6] o_fault_irq; endproperty
    a_irq: assert property (p_irq) else $error("no fault request");
    property p_idle; (o_state == ST_IDLE) [*2] |-> gate_any == 3'h0; endproperty
    a_idle: assert property (p_idle) else $error("pwm on while idle");
    property p_align; o_state == ST_IDLE && i_run |=> o_state == ST_ALIGN; endproperty
    a_align: assert property (p_align) else $error("no alignment");
    property p_trig; o_adc_trigger |=> !o_adc_trigger [*8]; endproperty
    a_trig: assert property (p_trig) else $error("trigger too long");
    property p_index; $rose(i_enc_index) |-> ##[2:4] o_position == 11'h0; endproperty
    a_index: assert property (p_index) else $error("index kept count");
endmodule : pvce_monitor
bind pvce_engine pvce_monitor i_mon (.i_clock, .i_rst, .i_run, .i_overcurrent, .i_pwm_kill,
    .i_enc_index, .o_pwm_hi, .o_pwm_lo, .o_adc_trigger, .o_fault_irq, .o_position, .o_state);

// ==== pvce_encoder_model.sv ====
// quadrature encoder model driving the phase pins
`timescale 1ns/1ns
module pvce_encoder_model (
    // clock and step command
    input wire logic i_clock,
    input wire logic i_step,
    input wire logic i_dir,
    // phase pins
    output logic o_a,
    output logic o_b
);
    logic [1:0] ph = 2'h0; // gray position, a leads b counting up
    always @(posedge i_clock) begin
        if (i_step) ph <= i_dir ? ph + 2'h1 : ph - 2'h1;
    end
    assign o_a = ph[0] ^ ph[1];
    assign o_b = ph[1];
endmodule : pvce_encoder_model

// ==== pvce_engine_tb.sv ====
// self-checking bench of the vector control engine
`timescale 1ns/1ns
module pvce_engine_tb;
    import pvce_pkg::*;
    logic i_clock = 0, i_rst = 1, i_enc_index = 0, i_overcurrent = 0, i_run = 0;
    logic i_pwm_kill = 0, i_fault_ack = 0, i_cur_valid = 0, step = 0, dir = 0, i_enc_a, i_enc_b;
    logic i_speed_mode = 0; // torque mode first, speed mode later
    logic [11:0] i_cur_a_raw = 12'h800, i_cur_b_raw = 12'h800, i_dcbus_raw = 12'h000;
    logic signed [15:0] i_torque_req = 16'sh0800, i_speed_req_rpm = 16'sh0000;
    logic [14:0] i_iq_limit = 15'h2000, i_vdq_limit = 15'h2000;
    logic [2:0] o_pwm_hi, o_pwm_lo;
    logic o_brake, o_adc_trigger, o_fault_irq;
    logic [10:0] o_position;
    logic [19:0] o_last_edge_time;
    logic signed [15:0] o_speed_rpm, o_iq;
    pvce_state_t o_state;
    int failures = 0, compares = 0, pos = 0, n, cyc = 0, t;
    always #25 i_clock = ~i_clock;
    // cycles since reset release, as the edge timebase counts them
    always @(posedge i_clock) cyc <= i_rst ? 0 : cyc + 1;
    pvce_encoder_model i_enc (.i_clock, .i_step(step), .i_dir(dir), .o_a(i_enc_a), .o_b(i_enc_b));
    pvce_engine #(.P_ALIGN_CYCLES(50), .P_SPEED_WIN(200)) i_dut (.i_clock, .i_rst, .i_enc_a,
        .i_enc_b, .i_enc_index, .i_overcurrent, .i_run, .i_speed_mode, .i_speed_req_rpm,
        .i_torque_req, .i_iq_limit, .i_vdq_limit, .i_pwm_kill, .i_fault_ack, .i_cur_valid,
        .i_cur_a_raw, .i_cur_b_raw, .i_dcbus_raw, .o_pwm_hi, .o_pwm_lo, .o_brake, .o_adc_trigger,
        .o_fault_irq, .o_position, .o_last_edge_time, .o_speed_rpm, .o_iq, .o_state);
    task report_and_stop;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : report_and_stop
    task chk(input string nm, input logic [19:0] seen, input logic [19:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : chk
    task tick(input int c);
        repeat (c) @(posedge i_clock);
        #1;
    endtask : tick
    // bench keeps an unwrapped count of steps, reduced mod 2000 when checked
    task enc(input int k, input logic d);
        repeat (k) begin
            @(posedge i_clock); step <= 1; dir <= d;
            @(posedge i_clock); step <= 0;
            t = cyc;
            tick(3);
            pos += d ? 1 : -1;
        end
        tick(4);
        chk("position", o_position, 20'((pos % 2000 + 2000) % 2000));
        chk("edge time", o_last_edge_time, 20'(t + 3));
    endtask : enc
    // bounded wait for a trigger pulse, then it must drop
    task trig;
        int k;
        for (k = 0; k < 1100 && o_adc_trigger !== 1'b1; k++) tick(1);
        if (k == 1100) begin failures++; report_and_stop; end
        tick(1);
        chk("trigger", o_adc_trigger, 0);
    endtask : trig
    initial begin
        void'($urandom(143));
        tick(12);
        i_rst <= 0;
        tick(1);
        chk("state", o_state, ST_IDLE);
        n = $urandom_range(30, 4);
        enc(n, 1);
        enc(n + 2, 0);
        // one edge per 5 cycles: 40 edges in every 200-cycle window
        enc(120, 0);
        chk("speed", o_speed_rpm, 20'(-40 * int'(RPM_PER_COUNT)));
        @(posedge i_clock); i_enc_index <= 1;
        tick(2); i_enc_index <= 0; pos = 0;
        tick(4);
        chk("index", o_position, 0);
        $display("encoder test done");
        i_torque_req <= 16'($urandom_range(4000, 0)); i_run <= 1;
        tick(1);
        chk("align", o_state, ST_ALIGN);
        tick(60);
        chk("run", o_state, ST_RUN);
        // alignment pattern applied: all legs high early in the period
        trig;
        tick(30);
        chk("align gates", {o_pwm_lo, o_pwm_hi}, 6'h07);
        repeat (3) begin
            trig;
            @(posedge i_clock); i_cur_valid <= 1;
            i_cur_a_raw <= 12'($urandom); i_cur_b_raw <= 12'($urandom);
            @(posedge i_clock); i_cur_valid <= 0;
        end
        i_speed_mode <= 1; i_speed_req_rpm <= 16'sd500;
        @(posedge i_clock); i_cur_valid <= 1; i_cur_a_raw <= 12'h800; i_cur_b_raw <= 12'h800;
        @(posedge i_clock); i_cur_valid <= 0;
        tick(2);
        chk("iq", o_iq, 0);
        $display("sample test done");
        i_overcurrent <= 1;
        tick(6);
        chk("oc gates", o_pwm_hi | o_pwm_lo, 0);
        chk("irq", o_fault_irq, 1);
        i_overcurrent <= 0; i_pwm_kill <= 1; i_fault_ack <= 1;
        tick(1); i_fault_ack <= 0;
        tick(4);
        chk("irq clear", o_fault_irq, 0);
        chk("kill gates", o_pwm_hi | o_pwm_lo, 0);
        i_pwm_kill <= 0; i_dcbus_raw <= 12'hc00;
        tick(5);
        chk("brake on", o_brake, 1);
        i_dcbus_raw <= 12'hb80;
        tick(5);
        chk("brake hold", o_brake, 1);
        i_dcbus_raw <= 12'hb00;
        tick(5);
        chk("brake off", o_brake, 0);
        i_run <= 0;
        tick(3);
        chk("stop", {o_state, o_pwm_hi, o_pwm_lo}, {ST_IDLE, 6'h00});
        $display("drive test done");
        report_and_stop;
    end
endmodule : pvce_engine_tb
